/* File: hdl/ccw_exec.sv */
/*
 * Execution unit for subroutine call, data byte clear, data bit clear
 * and the three watchdog clear instructions.
 * Assumes instruction class and operands arrive synchronous to clock,
 * data memory read data is valid in the cycle an instruction is taken,
 * and the watchdog counter and stack live outside this block.
 */
// Summary of operation
// - Call always jumps, nothing suppresses it
// - Call pushes program counter plus one
// - After push, load target into program counter
// - Call takes two instruction cycles
// - Byte clear writes zero to memory
// - Bit clear zeroes only selected bit
// - Single clear resets counter and both flags
// - First pre-clear clears only alternating with second
// - Repeated first pre-clear has no effect
// - Second pre-clear clears only alternating with first
// - Repeated second pre-clear has no effect
// - Pre-clears clear the flags only after both pre-clears
// - Program counter changes take two cycles
`timescale 1ns/1ps

module ccw_exec
	import ccw_pkg::*;
#(
	parameter int PC_W = CCW_PC_W,          // Program counter width
	parameter int MADDR_W = CCW_MADDR_W,    // Data memory address width
	parameter int BIT_W = CCW_BIT_W         // Bit index width
)
(
	input wire logic clock,
	input wire logic rst_b,
	input wire logic op_valid,
	output logic op_ready,
	input wire ccw_op_e op_class,
	input wire logic [PC_W-1:0] op_pc,
	input wire logic [PC_W-1:0] op_target,
	input wire logic [MADDR_W-1:0] op_maddr,
	input wire logic [BIT_W-1:0] op_bit,
	input wire logic [CCW_DATA_W-1:0] mem_rdata,
	output logic mem_we,
	output logic [MADDR_W-1:0] mem_waddr,
	output logic [CCW_DATA_W-1:0] mem_wdata,
	output logic stack_push,
	output logic [PC_W-1:0] stack_data,
	output logic pc_load,
	output logic [PC_W-1:0] pc_target,
	output logic watchdog_counter_clear,
	input wire logic timeout_set,
	input wire logic powerdown_set,
	output logic timeout_flag,
	output logic powerdown_flag
);

	////////////////////////////////////////////////////////////////////
	// Elaboration checks
	if (PC_W < 2 || PC_W > 16)
		$error("PC_W out of range");
	if (MADDR_W < 1 || (1 << BIT_W) != CCW_DATA_W)
		$error("address or bit index width unusable");

	////////////////////////////////////////////////////////////////////
	// Declarations
	ccw_state_e state_ff;                 // Sequencer state
	logic take;                           // Instruction accepted now
	logic [PC_W-1:0] target_ff;           // Held call target
	logic mem_we_ff;                      // Registered write strobe
	logic [MADDR_W-1:0] mem_waddr_ff;     // Registered write address
	logic [CCW_DATA_W-1:0] mem_wdata_ff;  // Registered write data
	logic [CCW_DATA_W-1:0] nxt_wdata;     // Write data being formed
	logic push_ff;                        // Registered push strobe
	logic [PC_W-1:0] push_data_ff;        // Return address
	logic pc_load_ff;                     // Registered jump strobe
	logic wdt_clr_ff;                     // Registered counter clear
	logic timeout_ff;                     // Timeout flag
	logic powerdown_ff;                   // Power-down flag

	ccw_wdt_if wif ();                    // Link to pairing tracker

	////////////////////////////////////////////////////////////////////
	// Handshake: no new instruction while the call finishes
	always_comb begin
		op_ready = (state_ff == CCW_ST_IDLE);
		take = op_valid && op_ready;
	end

	// Strobes to the pairing tracker
	always_comb begin
		wif.single_clear = take && op_class == CCW_OP_WDT_CLR;
		wif.pre_first = take && op_class == CCW_OP_PRE1;
		wif.pre_second = take && op_class == CCW_OP_PRE2;
	end

	ccw_preclear u_preclear (
		.clock(clock),
		.rst_b(rst_b),
		.w(wif.tracker)
	);

	////////////////////////////////////////////////////////////////////
	// Call sequencer; the jump lands one cycle after the push so the
	// stack sees the return address before the program counter moves
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			state_ff <= CCW_ST_IDLE;
		end else begin
			unique case (state_ff)
				CCW_ST_IDLE: begin
					// No condition gates the call
					if (take && op_class == CCW_OP_CALL)
						state_ff <= CCW_ST_CALL;
				end
				CCW_ST_CALL: begin
					// Second cycle of the call
					state_ff <= CCW_ST_IDLE;
				end
			endcase
		end
	end

	// Held target for the jump cycle
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			target_ff <= '0;
		end else if (take && op_class == CCW_OP_CALL) begin
			target_ff <= op_target;
		end
	end

	// Return address push, first cycle of the call
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			push_ff <= 1'b0;
			push_data_ff <= '0;
		end else begin
			push_ff <= take && op_class == CCW_OP_CALL;
			if (take && op_class == CCW_OP_CALL)
				push_data_ff <= op_pc + PC_W'(CCW_PC_STEP);
		end
	end

	// Jump strobe, second cycle of the call
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			pc_load_ff <= 1'b0;
		end else begin
			pc_load_ff <= (state_ff == CCW_ST_CALL);
		end
	end

	////////////////////////////////////////////////////////////////////
	// Memory clear data; bit clear is a read-modify-write, so the
	// unselected bits come from the byte read in the same cycle
	always_comb begin
		nxt_wdata = mem_rdata;
		if (op_class == CCW_OP_BYTE_CLR) begin
			nxt_wdata = CCW_BYTE_CLEAR;
		end else begin
			nxt_wdata[op_bit] = 1'b0;
		end
	end

	// Registered memory write; no arithmetic flag is ever touched here
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			mem_we_ff <= 1'b0;
			mem_waddr_ff <= '0;
			mem_wdata_ff <= '0;
		end else begin
			mem_we_ff <= take && (op_class == CCW_OP_BYTE_CLR
				|| op_class == CCW_OP_BIT_CLR);
			if (take) begin
				mem_waddr_ff <= op_maddr;
				mem_wdata_ff <= nxt_wdata;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Watchdog counter clear strobe
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			wdt_clr_ff <= 1'b0;
		end else begin
			wdt_clr_ff <= wif.do_clear;
		end
	end

	// Status flags; a set in the clearing cycle wins so no event is lost
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			timeout_ff <= CCW_FLAG_RESET;
			powerdown_ff <= CCW_FLAG_RESET;
		end else begin
			if (timeout_set)
				timeout_ff <= 1'b1;
			else if (wif.do_clear)
				timeout_ff <= 1'b0;
			if (powerdown_set)
				powerdown_ff <= 1'b1;
			else if (wif.do_clear)
				powerdown_ff <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Outputs
	always_comb begin
		mem_we = mem_we_ff;
		mem_waddr = mem_waddr_ff;
		mem_wdata = mem_wdata_ff;
		stack_push = push_ff;
		stack_data = push_data_ff;
		pc_load = pc_load_ff;
		pc_target = target_ff;
		watchdog_counter_clear = wdt_clr_ff;
		timeout_flag = timeout_ff;
		powerdown_flag = powerdown_ff;
	end

	////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);

	sequence s_call_taken;
		op_valid && op_ready && op_class == CCW_OP_CALL;
	endsequence

	sequence s_push_then_jump;
		stack_push && !pc_load ##1 pc_load && !stack_push;
	endsequence

	a_call_always_jumps: assert property (
		s_call_taken |-> ##1 s_push_then_jump)
		else $error("call did not push then jump");

	a_call_push_value: assert property (
		s_call_taken |=> stack_data == $past(op_pc) + PC_W'(1))
		else $error("pushed address is not pc plus one");

	a_call_jump_target: assert property (
		s_call_taken |-> ##2 pc_load && pc_target == $past(op_target, 2))
		else $error("jump target wrong");

	a_call_two_cycles: assert property (
		s_call_taken |=> !op_ready ##1 op_ready)
		else $error("call did not occupy two cycles");

	a_byte_clear_zero: assert property (
		op_valid && op_ready && op_class == CCW_OP_BYTE_CLR
		|=> mem_we && mem_wdata == 8'h00
		&& mem_waddr == $past(op_maddr))
		else $error("byte clear did not write zero");

	a_bit_clear_one: assert property (
		op_valid && op_ready && op_class == CCW_OP_BIT_CLR
		|=> mem_we && mem_wdata[$past(op_bit)] == 1'b0
		&& (mem_wdata | (8'h01 << $past(op_bit)))
		== ($past(mem_rdata) | (8'h01 << $past(op_bit))))
		else $error("bit clear disturbed other bits");

	a_single_clears_all: assert property (
		op_valid && op_ready && op_class == CCW_OP_WDT_CLR
		&& !timeout_set && !powerdown_set
		|=> watchdog_counter_clear && !timeout_flag && !powerdown_flag)
		else $error("single clear incomplete");

	a_pair_clears_flags: assert property (
		wif.pre_second && !wif.do_clear
		##1 wif.pre_first && !timeout_set
		|=> !timeout_flag && watchdog_counter_clear)
		else $error("alternating pre-clears did not clear");

	a_flags_hold_unpaired: assert property (
		!wif.do_clear && !timeout_set |=> timeout_flag == $past(timeout_flag))
		else $error("timeout flag changed without clear");

	a_no_mem_on_call: assert property (
		s_call_taken |=> !mem_we)
		else $error("call touched data memory");

endmodule

/* File: hdl/ccw_pkg.sv */
/*
 * Shared constants and types for the call / clear / watchdog-clear
 * execution unit.
 * Assumes a decoder upstream that classifies each instruction word.
 */
package ccw_pkg;

	// Default widths
	localparam int CCW_PC_W = 11;       // Program counter width
	localparam int CCW_DATA_W = 8;      // Data memory byte width
	localparam int CCW_MADDR_W = 7;     // Data memory address width
	localparam int CCW_BIT_W = 3;       // Bit index width

	// Cycle count and return address step
	localparam int CCW_CALL_CYCLES = 2;     // Call occupies two cycles
	localparam int CCW_PC_STEP = 1;         // Return address increment

	// Values written and held after reset
	localparam logic [7:0] CCW_BYTE_CLEAR = 8'h00;   // Cleared byte
	localparam logic CCW_FLAG_RESET = 1'b0;          // Flags after reset

	// Instruction classes handled by this unit
	typedef enum logic [2:0] {
		CCW_OP_OTHER,
		CCW_OP_CALL,
		CCW_OP_BYTE_CLR,
		CCW_OP_BIT_CLR,
		CCW_OP_WDT_CLR,
		CCW_OP_PRE1,
		CCW_OP_PRE2
	} ccw_op_e;

	// Which pre-clear ran last
	typedef enum logic [1:0] {
		CCW_PRE_NONE,
		CCW_PRE_FIRST,
		CCW_PRE_SECOND
	} ccw_pre_e;

	// Execution sequencer states
	typedef enum logic [0:0] {
		CCW_ST_IDLE,
		CCW_ST_CALL
	} ccw_state_e;

endpackage

/* File: hdl/ccw_wdt_if.sv */
/*
 * Strobes between the execution unit and its pre-clear pairing tracker.
 * Assumes both ends share the core clock; strobes last one cycle.
 */
`timescale 1ns/1ps

interface ccw_wdt_if;
	logic single_clear;   // Single watchdog clear executed
	logic pre_first;      // First pre-clear executed
	logic pre_second;     // Second pre-clear executed
	logic do_clear;       // Counter and flags must be cleared now

	modport exec (output single_clear, output pre_first,
		output pre_second, input do_clear);
	modport tracker (input single_clear, input pre_first,
		input pre_second, output do_clear);
endinterface

/* File: hdl/ccw_preclear.sv */
/*
 * Pairing tracker for the two pre-clear instructions.
 * Assumes at most one strobe of the interface is high per cycle.
 */
`timescale 1ns/1ps

module ccw_preclear
	import ccw_pkg::*;
(
	input wire logic clock,
	input wire logic rst_b,
	ccw_wdt_if.tracker w
);

	ccw_pre_e last_ff;    // Last pre-clear seen
	ccw_pre_e nxt_last;   // Next value of last_ff

	////////////////////////////////////////////////////////////////////
	// Clear decision: single clear always, a pre-clear only after its
	// partner, so a runaway loop of one kind cannot feed the watchdog
	always_comb begin
		w.do_clear = w.single_clear;
		nxt_last = last_ff;
		if (w.single_clear) begin
			// Start pairing afresh
			nxt_last = CCW_PRE_NONE;
		end else if (w.pre_first) begin
			if (last_ff == CCW_PRE_SECOND) begin
				w.do_clear = 1'b1;
				nxt_last = CCW_PRE_NONE;
			end else begin
				// Repeat of the first has no effect
				nxt_last = CCW_PRE_FIRST;
			end
		end else if (w.pre_second) begin
			if (last_ff == CCW_PRE_FIRST) begin
				w.do_clear = 1'b1;
				nxt_last = CCW_PRE_NONE;
			end else begin
				// Repeat of the second has no effect
				nxt_last = CCW_PRE_SECOND;
			end
		end
	end

	// Pairing memory
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			last_ff <= CCW_PRE_NONE;
		end else begin
			last_ff <= nxt_last;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Checks
	a_pre1_repeat_idle: assert property (@(posedge clock)
		disable iff (!rst_b)
		w.pre_first && last_ff != CCW_PRE_SECOND |-> !w.do_clear)
		else $error("first pre-clear cleared without partner");

	a_pre2_pair_clear: assert property (@(posedge clock)
		disable iff (!rst_b)
		w.pre_first && !w.do_clear ##1 w.pre_second |-> w.do_clear)
		else $error("second pre-clear after first did not clear");

	a_pre2_repeat_idle: assert property (@(posedge clock)
		disable iff (!rst_b)
		w.pre_second ##1 w.pre_second |-> !w.do_clear)
		else $error("repeated second pre-clear cleared");

endmodule

/* File: bench/ccw_prog_mem.sv */
/*
 * Program memory model that offers instruction words to the unit.
 * Assumes the bench fills it through put and it shares the core clock.
 */
`timescale 1ns/1ps

module ccw_prog_mem
	import ccw_pkg::*;
(
	input wire logic clock,
	input wire logic rst_b,
	input wire logic op_ready,
	input wire logic pc_load,
	input wire logic [CCW_PC_W-1:0] pc_target,
	output logic op_valid,
	output ccw_op_e op_class,
	output logic [CCW_PC_W-1:0] op_pc,
	output logic [CCW_PC_W-1:0] op_target,
	output logic [CCW_MADDR_W-1:0] op_maddr,
	output logic [CCW_BIT_W-1:0] op_bit
);
	logic [23:0] q[$]; // Class, target, address, bit
	logic [CCW_PC_W-1:0] pc; // Fetch address

	// Queue one word for fetch
	task automatic put(input logic [23:0] w);
		q.push_back(w);
	endtask

	////////////////////////////////////////////////////////////////////
	// Offer head word, hold it until the edge where it is taken
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			// Quiet offer while in reset
			q.delete();
			op_valid <= 1'b0;
			op_class <= CCW_OP_OTHER;
			{op_pc, op_target, op_maddr, op_bit} <= '0;
			pc = '0;
		end else begin
			// Follow a jump so later words carry the new address
			if (pc_load) begin
				pc = pc_target;
			end
			if (op_valid && op_ready) begin
				void'(q.pop_front());
				pc = pc + 1'b1;
			end
			if (q.size() > 0) begin
				op_valid <= 1'b1;
				op_class <= ccw_op_e'(q[0][23:21]);
				op_target <= q[0][20:10];
				op_maddr <= q[0][9:3];
				op_bit <= q[0][2:0];
				op_pc <= pc;
			end else begin
				// Nothing offered: fields wander so stale data shows
				op_valid <= 1'b0;
				op_class <= ccw_op_e'(~op_class);
				op_target <= ~op_target;
				op_maddr <= ~op_maddr;
				op_bit <= ~op_bit;
				op_pc <= ~op_pc;
			end
		end
	end
endmodule

/* File: bench/test_call_clear_watchdog_exec.sv */
/*
 * Self-checking bench: a cycle model is compared with every output.
 * Assumes the unit's hand-over timing and set-beats-clear on flags.
 */
`timescale 1ns/1ps

module test_call_clear_watchdog_exec
	import ccw_pkg::*;
;
	logic clock = 1'b0;
	logic rst_b;
	logic op_valid, op_ready;
	ccw_op_e op_class;
	logic [CCW_PC_W-1:0] op_pc, op_target, stack_data, pc_target;
	logic [CCW_MADDR_W-1:0] op_maddr, mem_waddr;
	logic [CCW_BIT_W-1:0] op_bit;
	logic [7:0] mem_rdata, mem_wdata;
	logic mem_we, stack_push, pc_load, watchdog_counter_clear;
	logic timeout_set, powerdown_set, timeout_flag, powerdown_flag;
	// Model state
	bit e_ready, e_we, e_push, e_load, e_clr, e_to, e_pd, pend, clr;
	logic [CCW_MADDR_W-1:0] e_waddr;
	logic [7:0] e_wdata;
	logic [CCW_PC_W-1:0] e_sdata, e_tgt, pend_tgt;
	int last; // 0 none, 1 first, 2 second pre-clear
	int miscompares = 0;
	int n_checks = 0;
	int cyc = 0;
	bit chk_on = 0;

	always #4 clock = ~clock;

	ccw_exec u_dut (.clock(clock), .rst_b(rst_b), .op_valid(op_valid),
		.op_ready(op_ready), .op_class(op_class), .op_pc(op_pc),
		.op_target(op_target), .op_maddr(op_maddr), .op_bit(op_bit),
		.mem_rdata(mem_rdata), .mem_we(mem_we), .mem_waddr(mem_waddr),
		.mem_wdata(mem_wdata), .stack_push(stack_push),
		.stack_data(stack_data), .pc_load(pc_load),
		.pc_target(pc_target),
		.watchdog_counter_clear(watchdog_counter_clear),
		.timeout_set(timeout_set), .powerdown_set(powerdown_set),
		.timeout_flag(timeout_flag), .powerdown_flag(powerdown_flag));

	ccw_prog_mem u_mem (.clock(clock), .rst_b(rst_b),
		.op_ready(op_ready), .pc_load(pc_load), .pc_target(pc_target),
		.op_valid(op_valid), .op_class(op_class), .op_pc(op_pc),
		.op_target(op_target), .op_maddr(op_maddr), .op_bit(op_bit));

	// Compare one value and count it
	task automatic chk(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Counts, verdict, end of run
	task automatic results;
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// Queue one instruction with random operands
	task automatic ld(input ccw_op_e c);
		u_mem.put({c, CCW_PC_W'($urandom), 7'($urandom), 3'($urandom)});
	endtask

	// Wait until the memory model has no words left
	task automatic drain;
		while (u_mem.q.size() != 0) begin
			@(posedge clock);
		end
		repeat (4) @(posedge clock);
	endtask

	////////////////////////////////////////////////////////////////////
	// Cycle model: expected registered outputs after each edge
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			{e_we, e_push, e_load, e_clr, e_to, e_pd, pend} = '0;
			e_ready = 1'b1;
			last = 0;
		end else begin
			{clr, e_we, e_push} = '0;
			e_load = pend;
			e_tgt = pend_tgt;
			pend = 1'b0;
			if (op_valid && e_ready) begin
				case (op_class)
					CCW_OP_CALL: begin
						e_push = 1'b1;
						e_sdata = op_pc + 1'b1;
						pend = 1'b1;
						pend_tgt = op_target;
					end
					CCW_OP_BYTE_CLR, CCW_OP_BIT_CLR: begin
						e_we = 1'b1;
						e_waddr = op_maddr;
						e_wdata = CCW_BYTE_CLEAR;
						if (op_class == CCW_OP_BIT_CLR) begin
							e_wdata = mem_rdata;
							e_wdata[op_bit] = 1'b0;
						end
					end
					CCW_OP_WDT_CLR: begin
						clr = 1'b1;
						last = 0;
					end
					CCW_OP_PRE1: begin
						clr = (last == 2);
						last = clr ? 0 : 1;
					end
					CCW_OP_PRE2: begin
						clr = (last == 1);
						last = clr ? 0 : 2;
					end
					default: begin
					end
				endcase
			end
			// Second call cycle refuses the next offer
			e_ready = !pend;
			e_clr = clr;
			e_to = timeout_set | (e_to & !clr);
			e_pd = powerdown_set | (e_pd & !clr);
		end
	end

	// Compare on the falling edge, where outputs have settled
	always @(negedge clock) begin
		if (chk_on) begin
			chk("op_ready", op_ready, e_ready);
			chk("mem_we", mem_we, e_we);
			if (e_we) chk("mem_waddr", mem_waddr, e_waddr);
			if (e_we) chk("mem_wdata", mem_wdata, e_wdata);
			chk("stack_push", stack_push, e_push);
			if (e_push) chk("stack_data", stack_data, e_sdata);
			chk("pc_load", pc_load, e_load);
			if (e_load) chk("pc_target", pc_target, e_tgt);
			chk("wdt_clear", watchdog_counter_clear, e_clr);
			chk("timeout_flag", timeout_flag, e_to);
			chk("powerdown_flag", powerdown_flag, e_pd);
		end
	end

	// Random data and flag sets each cycle, plus hang guard
	always @(posedge clock) begin
		mem_rdata <= 8'($urandom);
		timeout_set <= ($urandom_range(0, 3) == 0);
		powerdown_set <= ($urandom_range(0, 3) == 0);
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			results();
		end
	end

	////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		ccw_op_e dir[$];
		rst_b = 1'b0;
		void'($urandom(27006));
		repeat (20) @(posedge clock);
		chk_on = 1;
		rst_b <= 1'b1;
		// Partner empties its queue in reset, so load after release
		@(posedge clock);
		// Awkward pairings, back-to-back calls, mixed clears
		dir = '{CCW_OP_PRE1, CCW_OP_PRE1, CCW_OP_PRE2, CCW_OP_PRE2,
			CCW_OP_PRE2, CCW_OP_OTHER, CCW_OP_PRE1, CCW_OP_CALL,
			CCW_OP_CALL, CCW_OP_BYTE_CLR, CCW_OP_BIT_CLR,
			CCW_OP_WDT_CLR, CCW_OP_PRE1, CCW_OP_WDT_CLR, CCW_OP_PRE2,
			CCW_OP_CALL, CCW_OP_BYTE_CLR};
		foreach (dir[i]) ld(dir[i]);
		// Every bit index of the bit clear
		for (int i = 0; i < 8; i++) begin
			u_mem.put({CCW_OP_BIT_CLR, 11'h7ff, 7'($urandom), 3'(i)});
		end
		drain();
		// Reset in the middle of traffic
		repeat (40) ld(ccw_op_e'($urandom_range(0, 6)));
		repeat (25) @(posedge clock);
		rst_b <= 1'b0;
		repeat (3) @(posedge clock);
		rst_b <= 1'b1;
		@(posedge clock);
		repeat (400) ld(ccw_op_e'($urandom_range(0, 6)));
		drain();
		results();
	end
endmodule
